// File: hdl/irq_controller.sv
// Purpose: interrupt and exception source map and arbiter toward the cpu core
// Assumes: request inputs are synchronous one-cycle pulses except the nmi pin
// Notes: registers on classic Wishbone, one-cycle ack, no wait states
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
module irq_controller
  import irq_map_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // request sources
  input wire logic nmi_pin,
  input wire logic [NUM_UNITS-1:0] timer_overflow_request,
  input wire logic [NUM_SHARED-1:0] ext_pin_request,
  input wire logic [NUM_SHARED-1:0] compare_match_request,
  input wire logic [1:0] second_timer_match_request,
  input wire logic [3:0] dma_end_request,
  input wire logic [8:0] serial_request,
  input wire logic clocked_serial_done_request,
  input wire logic conversion_end_request,
  // cpu side
  input wire logic soft_trap_req,
  input wire logic [4:0] soft_trap_vector,
  input wire logic illegal_opcode_trap,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] current_pc,
  input wire logic divide_busy,
  input wire logic irq_disable_flag,
  input wire logic nmi_in_service_flag,
  input wire logic cpu_ack,
  output logic irq_req,
  output logic [15:0] exc_code,
  output logic [31:0] handler_addr,
  output logic [31:0] maskable_saved_pc,
  output logic [31:0] nonmaskable_saved_pc,
  output logic [31:0] fault_addr,
  output logic exc_valid
);
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic nmi_edge_select;
    logic nmi_pending;
    logic [LEVEL_W:0] cur_level;
    logic [NUM_MASKABLE-1:0] mask;
    logic [NUM_MASKABLE-1:0] pending;
    logic [NUM_SHARED-1:0] shared_slot_select;
    logic [NUM_UNITS*4-1:0] timer_unit_mode_reg;
    logic [NUM_MASKABLE*LEVEL_W-1:0] levels;
    logic hold_maskable;
    logic [15:0] code;
    logic [31:0] handler;
    logic [31:0] mpc;
    logic [31:0] npc;
    logic [31:0] fault;
    logic exc_valid;
  } state_s;

  state_s r;
  state_s next_r;
  irq_sel_if sel_bus ();

  irq_priority_select u_sel (
    .s(sel_bus)
  );

  logic [NUM_MASKABLE-1:0] raw_req;
  logic [NUM_SHARED-1:0] shared_req;
  logic nmi_fire;
  logic bus_hit;
  logic [31:0] rd_word;

  assign bus_hit = wb_cyc_i && wb_stb_i && !r.ack;

  always_comb begin
    for (int k = 0; k < NUM_SHARED; k++) begin
      shared_req[k] = r.shared_slot_select[k] ? compare_match_request[k]
                                              : ext_pin_request[k];
    end
    raw_req = {conversion_end_request, clocked_serial_done_request, serial_request,
               dma_end_request, second_timer_match_request, shared_req,
               timer_overflow_request};
  end

  // edge on the synchronised pin, selected polarity
  assign nmi_fire = r.nmi_edge_select ? (r.nmi_sync && !r.nmi_prev)
                                      : (!r.nmi_sync && r.nmi_prev);

  always_comb begin
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      sel_bus.eligible[i] = r.pending[i] && !r.mask[i]
          && ({1'b0, r.levels[i*LEVEL_W +: LEVEL_W]} < r.cur_level);
    end
    sel_bus.levels = r.levels;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  always_comb begin
    rd_word = '0;
    if (wb_adr_i == REG_CTRL) begin
      rd_word[CTRL_NMI_EDGE] = r.nmi_edge_select;
      rd_word[CTRL_CUR_LEVEL_LSB +: LEVEL_W+1] = r.cur_level;
    end else if (wb_adr_i == REG_MASK_LO) begin
      rd_word = r.mask[31:0];
    end else if (wb_adr_i == REG_MASK_HI) begin
      rd_word = {17'h00000, r.mask[NUM_MASKABLE-1:32]};
    end else if (wb_adr_i == REG_PEND_LO) begin
      rd_word = r.pending[31:0];
    end else if (wb_adr_i == REG_PEND_HI) begin
      rd_word = {17'h00000, r.pending[NUM_MASKABLE-1:32]};
    end else if (wb_adr_i == REG_SLOT_SEL) begin
      rd_word = {8'h00, r.shared_slot_select};
    end else if (wb_adr_i == REG_STATUS) begin
      rd_word = {24'h000000, 2'b00, r.hold_maskable, r.nmi_pending, r.exc_valid,
                 sel_bus.found, r.nmi_sync, irq_req};
    end else if (wb_adr_i >= REG_MODE_BASE && wb_adr_i < REG_MODE_BASE + 8'(NUM_UNITS*4)
                 && wb_adr_i[1:0] == 2'b00) begin
      rd_word = {28'h0000000,
                 r.timer_unit_mode_reg[(wb_adr_i[4:2] - REG_MODE_BASE[4:2])*4 +: 4]};
    end else if (wb_adr_i >= REG_LEVEL_BASE && wb_adr_i <= REG_LEVEL_END
                 && wb_adr_i[1:0] == 2'b00) begin
      for (int j = 0; j < LEVELS_PER_WORD; j++) begin
        // word index from bits 5:2, the base has them clear, so no alias above 0x54
        if (int'(wb_adr_i[5:2]) * LEVELS_PER_WORD + j < NUM_MASKABLE) begin
          rd_word[j*4 +: LEVEL_W] =
              r.levels[(int'(wb_adr_i[5:2]) * LEVELS_PER_WORD + j) * LEVEL_W +: LEVEL_W];
        end
      end
    end
  end

  always_comb begin
    logic [31:0] w;
    logic grant_nmi;
    logic grant_mask;
    w = '0;
    next_r = r;
    next_r.ack = bus_hit;
    next_r.dat = bus_hit && !wb_we_i ? rd_word : r.dat;
    next_r.nmi_meta = nmi_pin;
    next_r.nmi_sync = r.nmi_meta;
    next_r.nmi_prev = r.nmi_sync;
    // shared-slot select mirrors the four mode bits of each unit
    for (int u = 0; u < NUM_UNITS; u++) begin
      for (int b = 0; b < 4; b++) begin
        next_r.shared_slot_select[u*4+b] = r.timer_unit_mode_reg[u*4+b];
      end
    end
    if (bus_hit && wb_we_i) begin
      if (wb_adr_i == REG_CTRL) begin
        w = merge({24'h000000, r.cur_level, 3'b000, r.nmi_edge_select}, wb_dat_i, wb_sel_i);
        next_r.nmi_edge_select = w[CTRL_NMI_EDGE];
        next_r.cur_level = w[CTRL_CUR_LEVEL_LSB +: LEVEL_W+1];
        next_r.hold_maskable = 1'b0; // re-enable after acknowledge
      end else if (wb_adr_i == REG_MASK_LO) begin
        next_r.mask[31:0] = merge(r.mask[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == REG_MASK_HI) begin
        w = merge({17'h00000, r.mask[NUM_MASKABLE-1:32]}, wb_dat_i, wb_sel_i);
        next_r.mask[NUM_MASKABLE-1:32] = w[NUM_MASKABLE-33:0];
      end else if (wb_adr_i >= REG_MODE_BASE && wb_adr_i < REG_MODE_BASE + 8'(NUM_UNITS*4)
                   && wb_adr_i[1:0] == 2'b00 && wb_sel_i[0]) begin
        next_r.timer_unit_mode_reg[(wb_adr_i[4:2] - REG_MODE_BASE[4:2])*4 +: 4] =
            wb_dat_i[3:0];
      end else if (wb_adr_i >= REG_LEVEL_BASE && wb_adr_i <= REG_LEVEL_END
                   && wb_adr_i[1:0] == 2'b00) begin
        for (int j = 0; j < LEVELS_PER_WORD; j++) begin
          if (int'(wb_adr_i[5:2]) * LEVELS_PER_WORD + j < NUM_MASKABLE
              && wb_sel_i[j/2]) begin
            next_r.levels[(int'(wb_adr_i[5:2]) * LEVELS_PER_WORD + j) * LEVEL_W +: LEVEL_W] =
                wb_dat_i[j*4 +: LEVEL_W];
          end
        end
      end
    end
    // one pending nmi kept however many edges arrive during service
    grant_nmi = cpu_ack && irq_req && r.nmi_pending;
    // a trap in the same cycle wins; the maskable stays pending and is offered again
    grant_mask = cpu_ack && irq_req && !r.nmi_pending && !illegal_opcode_trap && !soft_trap_req;
    if (grant_nmi) begin
      next_r.nmi_pending = 1'b0;
    end
    if (nmi_fire) begin
      next_r.nmi_pending = 1'b1;
    end
    next_r.pending = r.pending;
    if (grant_mask) begin
      next_r.pending[sel_bus.winner] = 1'b0;
      next_r.hold_maskable = 1'b1;
    end
    next_r.pending = next_r.pending | raw_req;
    next_r.exc_valid = 1'b0;
    if (grant_nmi) begin
      next_r.code = CODE_NMI;
      next_r.handler = HANDLER_NMI;
      next_r.npc = divide_busy ? current_pc : next_pc;
      next_r.exc_valid = 1'b1;
    end else if (illegal_opcode_trap) begin
      next_r.code = CODE_ILLEGAL;
      next_r.handler = HANDLER_ILLEGAL;
      next_r.mpc = next_pc;
      next_r.fault = next_pc - INSN_BYTES;
      next_r.exc_valid = 1'b1;
    end else if (soft_trap_req) begin
      next_r.code = (soft_trap_vector[4] ? CODE_TRAP_HIGH : CODE_TRAP_LOW)
                    | {12'h000, soft_trap_vector[3:0]};
      next_r.handler = soft_trap_vector[4] ? HANDLER_TRAP_HIGH : HANDLER_TRAP_LOW;
      next_r.mpc = next_pc;
      next_r.exc_valid = 1'b1;
    end else if (grant_mask) begin
      next_r.code = maskable_code(sel_bus.winner);
      next_r.handler = {16'h0000, maskable_code(sel_bus.winner)};
      next_r.mpc = divide_busy ? current_pc : next_pc;
      next_r.exc_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.cur_level <= CUR_LEVEL_RESET;
      r.levels <= {NUM_MASKABLE{LEVEL_RESET}};
      r.mask <= '1;
      r.timer_unit_mode_reg <= {NUM_UNITS{MODE_RESET}};
      r.code <= CODE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // nmi outranks everything and ignores irq_disable_flag and the post-grant hold, but waits while nmi_in_service_flag is set
  always_comb begin
    irq_req = r.nmi_pending && !nmi_in_service_flag;
    if (!r.nmi_pending) begin
      irq_req = sel_bus.found && !irq_disable_flag && !nmi_in_service_flag
                && !r.hold_maskable;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign exc_code = r.code;
  assign handler_addr = r.handler;
  assign maskable_saved_pc = r.mpc;
  assign nonmaskable_saved_pc = r.npc;
  assign fault_addr = r.fault;
  assign exc_valid = r.exc_valid;
endmodule : irq_controller

// File: hdl/irq_map_pkg.sv
// Purpose: constants and types for the interrupt vector and priority map
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone slave
package irq_map_pkg;
  localparam int NUM_MASKABLE = 47;
  localparam int NUM_SHARED = 24;
  localparam int NUM_UNITS = 6;
  localparam int LEVEL_W = 3;
  localparam int SRC_W = 6;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CODE_NMI = 16'h0010;
  localparam logic [15:0] CODE_TRAP_LOW = 16'h0040;
  localparam logic [15:0] CODE_TRAP_HIGH = 16'h0050;
  localparam logic [15:0] CODE_ILLEGAL = 16'h0060;
  localparam logic [15:0] CODE_OVF_BASE = 16'h0080;
  localparam logic [15:0] CODE_SHARED_BASE = 16'h0100;
  localparam logic [15:0] CODE_CMP2_BASE = 16'h0280;
  localparam logic [15:0] CODE_SERIAL_BASE = 16'h0300;
  localparam logic [15:0] CODE_CSI3 = 16'h03C0;
  localparam logic [15:0] CODE_ADC = 16'h0400;
  localparam logic [15:0] CODE_STEP = 16'h0010;
  localparam logic [31:0] HANDLER_NMI = 32'h0000_0010;
  localparam logic [31:0] HANDLER_TRAP_LOW = 32'h0000_0040;
  localparam logic [31:0] HANDLER_TRAP_HIGH = 32'h0000_0050;
  localparam logic [31:0] HANDLER_ILLEGAL = 32'h0000_0060;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
  localparam int PRI_SHARED = 6;
  localparam int PRI_CMP2 = 30;
  localparam int PRI_DMA = 32;
  localparam int PRI_SERIAL = 36;
  localparam int PRI_CSI3 = 45;
  localparam int PRI_ADC = 46;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MASK_LO = 8'h04;
  localparam logic [7:0] REG_MASK_HI = 8'h08;
  localparam logic [7:0] REG_PEND_LO = 8'h0C;
  localparam logic [7:0] REG_PEND_HI = 8'h10;
  localparam logic [7:0] REG_SLOT_SEL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_MODE_BASE = 8'h20;
  localparam logic [7:0] REG_LEVEL_BASE = 8'h40;
  localparam logic [7:0] REG_LEVEL_END = 8'h7C;
  localparam int LEVELS_PER_WORD = 8;
  // ctrl register fields
  localparam int CTRL_NMI_EDGE = 0;
  localparam int CTRL_CUR_LEVEL_LSB = 4;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h7;
  // current level 0x7 plus one above means nothing withheld by level at reset
  localparam logic [LEVEL_W:0] CUR_LEVEL_RESET = 4'h8;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_NMI,
    KIND_MASKABLE
  } grant_kind_e;

  function automatic logic [15:0] maskable_code(input logic [SRC_W-1:0] idx);
    logic [15:0] i16;
    i16 = {10'h000, idx};
    if (i16 < 16'(PRI_SHARED)) begin
      return CODE_OVF_BASE + 16'(i16 * CODE_STEP);
    end else if (i16 < 16'(PRI_CMP2)) begin
      return CODE_SHARED_BASE + 16'((i16 - 16'(PRI_SHARED)) * CODE_STEP);
    end else if (i16 < 16'(PRI_SERIAL)) begin
      return CODE_CMP2_BASE + 16'((i16 - 16'(PRI_CMP2)) * CODE_STEP);
    end else if (i16 < 16'(PRI_CSI3)) begin
      return CODE_SERIAL_BASE + 16'((i16 - 16'(PRI_SERIAL)) * CODE_STEP);
    end else if (i16 == 16'(PRI_CSI3)) begin
      return CODE_CSI3;
    end
    return CODE_ADC;
  endfunction : maskable_code
endpackage : irq_map_pkg

// File: hdl/irq_sel_if.sv
// Purpose: carries pending maskable requests and the chosen winner
// Assumes: same clock on both ends
// Notes: the selector is purely combinational
interface irq_sel_if;
  import irq_map_pkg::*;
  logic [NUM_MASKABLE-1:0] eligible;
  logic [NUM_MASKABLE*LEVEL_W-1:0] levels;
  logic found;
  logic [SRC_W-1:0] winner;
  logic [LEVEL_W-1:0] winner_level;
  modport ctrl (output eligible, output levels, input found, input winner, input winner_level);
  modport sel (input eligible, input levels, output found, output winner, output winner_level);
endinterface : irq_sel_if

// File: hdl/irq_priority_select.sv
// Purpose: picks the best eligible maskable source
// Assumes: eligible already gated by mask and level
// Notes: lower programmable level wins, ties go to higher default priority (smaller index)
module irq_priority_select
  import irq_map_pkg::*;
(
  irq_sel_if.sel s
);
  always_comb begin
    logic [LEVEL_W-1:0] lv;
    lv = '0;
    s.found = 1'b0;
    s.winner = '0;
    s.winner_level = '0;
    // scan from lowest default priority so smaller index overrides on equal level
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      lv = s.levels[i*LEVEL_W +: LEVEL_W];
      if (s.eligible[i] && (!s.found || lv <= s.winner_level)) begin
        s.found = 1'b1;
        s.winner = SRC_W'(i);
        s.winner_level = lv;
      end
    end
  end
endmodule : irq_priority_select

// File: verification/irq_controller_asserts.sv
// Purpose: port-level checks of the irq map controller
// Assumes: one clock, srst synchronous active high
// Notes: trap checks skip cycles where a cpu grant competes
module irq_controller_asserts
  import irq_map_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic soft_trap_req,
  input wire logic [4:0] soft_trap_vector,
  input wire logic illegal_opcode_trap,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] current_pc,
  input wire logic divide_busy,
  input wire logic irq_disable_flag,
  input wire logic cpu_ack,
  input wire logic irq_req,
  input wire logic [15:0] exc_code,
  input wire logic [31:0] handler_addr,
  input wire logic [31:0] maskable_saved_pc,
  input wire logic [31:0] fault_addr,
  input wire logic exc_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_TAKEN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("access not acked next cycle");
  AST_RESET_OUT: assert property ($past(srst) |-> exc_code == CODE_RESET && handler_addr == 32'h0)
    else $error("outputs not cleared by reset");
  AST_GRANT_NEXT: assert property (cpu_ack && irq_req |=> exc_valid)
    else $error("grant without exception pulse");
  AST_NMI_VEC: assert property (exc_valid && exc_code == CODE_NMI |-> handler_addr == HANDLER_NMI)
    else $error("nmi handler wrong");
  AST_TRAP: assert property (soft_trap_req && !illegal_opcode_trap && !(cpu_ack && irq_req) |=>
    exc_valid && exc_code == CODE_TRAP_LOW + 16'($past(soft_trap_vector)) &&
    handler_addr == ($past(soft_trap_vector[4]) ? HANDLER_TRAP_HIGH : HANDLER_TRAP_LOW))
    else $error("trap code or handler wrong");
  AST_ILLEGAL: assert property (illegal_opcode_trap && !(cpu_ack && irq_req) |=>
    exc_code == CODE_ILLEGAL && handler_addr == HANDLER_ILLEGAL &&
    fault_addr == $past(next_pc) - INSN_BYTES)
    else $error("illegal opcode result wrong");
  AST_MASK_VEC: assert property (exc_valid && exc_code >= CODE_OVF_BASE |->
    handler_addr == {16'h0000, exc_code})
    else $error("maskable handler differs from code");
  AST_DIV_PC: assert property (cpu_ack && irq_req && divide_busy ##1 exc_code >= CODE_OVF_BASE
    |-> maskable_saved_pc == $past(current_pc))
    else $error("divide saved pc wrong");
  AST_SAVE_NEXT: assert property (cpu_ack && irq_req && !divide_busy ##1 exc_code >= CODE_OVF_BASE
    |-> maskable_saved_pc == $past(next_pc))
    else $error("saved pc not next pc");
  AST_DISABLED: assert property (cpu_ack && irq_req && irq_disable_flag |=> exc_code == CODE_NMI)
    else $error("maskable granted while disabled");
  COV_TRAP: cover property (soft_trap_req && soft_trap_vector[4]);
  COV_DIV: cover property (cpu_ack && irq_req && divide_busy);
  COV_NMI: cover property (exc_valid && exc_code == CODE_NMI);
endmodule : irq_controller_asserts
bind irq_controller irq_controller_asserts chk_u (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .soft_trap_req, .soft_trap_vector, .illegal_opcode_trap, .next_pc, .current_pc, .divide_busy,
  .irq_disable_flag, .cpu_ack, .irq_req, .exc_code, .handler_addr, .maskable_saved_pc,
  .fault_addr, .exc_valid);

// File: verification/cpu_core_model.sv
// Purpose: cpu core stand-in that takes presented exceptions
// Assumes: ack_delay steady while a request is presented
// Notes: registered ack, so the fastest answer comes one cycle after irq_req
module cpu_core_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic [3:0] ack_delay,
  output logic cpu_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (cpu_ack || !irq_req) begin
      cpu_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= ack_delay) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : cpu_core_model

// File: verification/tb_irq_controller.sv
// Purpose: self-checking bench for the irq map controller
// Assumes: cpu model acks every presented request
// Notes: pc inputs held steady so saved values are known
module tb_irq_controller
  import irq_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, nmi_pin = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, ack_delay = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, rd, next_pc = 32'h0000_1004, current_pc = 32'h0000_1000;
  logic [46:0] rq = '0;
  logic [23:0] compare_match_request = '0;
  logic soft_trap_req = 0, illegal_opcode_trap = 0, divide_busy = 0;
  logic irq_disable_flag = 0, nmi_in_service_flag = 0;
  logic [4:0] soft_trap_vector = 5'h00;
  logic [31:0] wb_dat_o, handler_addr, maskable_saved_pc, nonmaskable_saved_pc, fault_addr;
  logic [15:0] exc_code;
  logic wb_ack_o, irq_req, cpu_ack, exc_valid;
  wire logic [5:0] timer_overflow_request = rq[5:0];
  wire logic [23:0] ext_pin_request = rq[29:6];
  wire logic [1:0] second_timer_match_request = rq[31:30];
  wire logic [3:0] dma_end_request = rq[35:32];
  wire logic [8:0] serial_request = rq[44:36];
  wire logic clocked_serial_done_request = rq[45];
  wire logic conversion_end_request = rq[46];
  int error_cnt = 0, n_checks = 0, cyc_cnt = 0;
  int src_tab [12] = '{0, 5, 6, 29, 30, 31, 32, 35, 36, 44, 45, 46};
  logic [15:0] code_tab [12] = '{16'h0080, 16'h00D0, 16'h0100, 16'h0270, 16'h0280, 16'h0290,
    16'h02A0, 16'h02D0, 16'h0300, 16'h0380, 16'h03C0, 16'h0400};
  irq_controller dut_u (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .nmi_pin, .timer_overflow_request, .ext_pin_request,
    .compare_match_request, .second_timer_match_request, .dma_end_request, .serial_request,
    .clocked_serial_done_request, .conversion_end_request, .soft_trap_req, .soft_trap_vector,
    .illegal_opcode_trap, .next_pc, .current_pc, .divide_busy, .irq_disable_flag,
    .nmi_in_service_flag, .cpu_ack, .irq_req, .exc_code, .handler_addr, .maskable_saved_pc,
    .nonmaskable_saved_pc, .fault_addr, .exc_valid);
  cpu_core_model cpu_u (.clk, .srst, .irq_req, .ack_delay, .cpu_ack);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic pulse(input logic [46:0] m);
    @(posedge clk);
    rq <= m;
    @(posedge clk);
    rq <= '0;
  endtask : pulse
  task automatic expect_exc(input logic [15:0] c, input logic [31:0] h);
    int k;
    k = 0;
    @(posedge clk);
    while (exc_valid !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk(exc_valid, 1);
    chk(exc_code, c);
    chk(handler_addr, h);
  endtask : expect_exc
  task automatic quiet();
    repeat (6) begin
      @(posedge clk);
      chk(irq_req, 0);
    end
  endtask : quiet
  // ctrl write restores full level and clears the post-grant hold
  task automatic clr();
    wb(1, REG_CTRL, 32'h0000_0081);
  endtask : clr
  task automatic trap(input logic t, input logic [4:0] v);
    @(posedge clk);
    {soft_trap_req, illegal_opcode_trap, soft_trap_vector} <= {t, !t, v};
    @(posedge clk);
    {soft_trap_req, illegal_opcode_trap} <= 2'b00;
  endtask : trap
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk({exc_code, 15'h0, irq_req}, 0);
    chk(handler_addr, 0);
    wb(0, REG_MASK_LO, 0);
    chk(rd, 32'hFFFF_FFFF);
    wb(0, 8'hFC, 0);
    chk(rd, 0);
    wb(1, REG_MASK_LO, 0);
    wb(1, REG_MASK_HI, 0);
    clr();
    for (int i = 0; i < 12; i++) begin
      pulse(47'(1) << src_tab[i]);
      expect_exc(code_tab[i], {16'h0, code_tab[i]});
      chk(maskable_saved_pc, 32'h0000_1004);
      clr();
    end
    $display("test source map done");
    pulse((47'(1) << 3) | (47'(1) << 40));
    expect_exc(16'h00B0, 32'h0000_00B0);
    quiet();
    clr();
    expect_exc(16'h0340, 32'h0000_0340);
    clr();
    wb(1, REG_MASK_LO, 32'h0000_0400);
    pulse(47'(1) << 10);
    quiet();
    wb(1, REG_MASK_LO, 0);
    expect_exc(16'h0140, 32'h0000_0140);
    wb(1, REG_CTRL, 32'h0000_0001);
    pulse(47'(1) << 2);
    quiet();
    clr();
    expect_exc(16'h00A0, 32'h0000_00A0);
    clr();
    wb(1, REG_LEVEL_BASE + 8'h04, 32'h7777_7707);
    pulse((47'(1) << 1) | (47'(1) << 9));
    expect_exc(16'h0130, 32'h0000_0130);
    clr();
    expect_exc(16'h0090, 32'h0000_0090);
    wb(1, REG_LEVEL_BASE + 8'h04, 32'h7777_7777);
    wb(1, REG_MODE_BASE, 32'h0000_0001);
    clr();
    pulse(47'(1) << 6);
    quiet();
    @(posedge clk);
    compare_match_request <= 24'h000001;
    @(posedge clk);
    compare_match_request <= 24'h000000;
    expect_exc(16'h0100, 32'h0000_0100);
    wb(1, REG_MODE_BASE, 0);
    clr();
    irq_disable_flag <= 1;
    pulse(47'(1));
    quiet();
    irq_disable_flag <= 0;
    expect_exc(16'h0080, 32'h0000_0080);
    clr();
    divide_busy <= 1;
    pulse(47'(1) << 4);
    expect_exc(16'h00C0, 32'h0000_00C0);
    chk(maskable_saved_pc, 32'h0000_1000);
    divide_busy <= 0;
    clr();
    $display("test arbitration done");
    for (int v = 0; v < 32; v++) begin
      trap(1, 5'(v));
      // codes 004n then 005n run on as one sequence from 0040H
      expect_exc(CODE_TRAP_LOW + 16'(v), v < 16 ? HANDLER_TRAP_LOW : HANDLER_TRAP_HIGH);
    end
    trap(0, 5'h00);
    expect_exc(CODE_ILLEGAL, HANDLER_ILLEGAL);
    chk(fault_addr, 32'h0000_1000);
    $display("test exceptions done");
    ack_delay <= 4'h3;
    irq_disable_flag <= 1;
    nmi_pin <= 1;
    expect_exc(CODE_NMI, HANDLER_NMI);
    chk(nonmaskable_saved_pc, 32'h0000_1004);
    irq_disable_flag <= 0;
    wb(1, REG_CTRL, 32'h0000_0080);
    nmi_pin <= 0;
    expect_exc(CODE_NMI, HANDLER_NMI);
    nmi_in_service_flag <= 1;
    repeat (2) begin
      repeat (5) @(posedge clk);
      nmi_pin <= 1;
      repeat (5) @(posedge clk);
      nmi_pin <= 0;
    end
    quiet();
    nmi_in_service_flag <= 0;
    expect_exc(CODE_NMI, HANDLER_NMI);
    quiet();
    $display("test nmi done");
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk({exc_code, 15'h0, irq_req}, 0);
    chk(handler_addr, 0);
    wb(0, REG_MASK_HI, 0);
    chk(rd, 32'h0000_7FFF);
    $display("test reset done");
    close_out();
  end
endmodule : tb_irq_controller
